/* testbench/board_pins.sv */
// Purpose: Board model that resolves the port C, D and G pin levels seen by the device.
// Assumes: Every pin has a pull-up; the board may drive any pin through ext_en.
// Notes: Contention with an enabled device driver is not modelled; the device wins.
`timescale 1ns/1ps
module board_pins
    import gpio_cdfg_pkg::*;
(
    input wire pin_drive_t c_drv,
    input wire pin_drive_t d_drv,
    input wire pin_drive_t g_drv,
    input wire logic [7:0] ext_val,
    input wire logic [7:0] ext_en,
    output logic [7:0] c_in,
    output logic [7:0] d_in,
    output logic [7:0] g_in
);
    // A released pin floats up to the pull-up level, never to its last driven value.
    function automatic logic [7:0] level(input pin_drive_t drv, input logic [7:0] v,
                                         input logic [7:0] en);
        return (drv.oe & drv.out) | (~drv.oe & ((en & v) | ~en));
    endfunction

    // Each port sees the wired result of device drive, board drive and pull-up.
    assign c_in = level(c_drv, ext_val, ext_en);
    assign d_in = level(d_drv, ext_val, ext_en);
    assign g_in = level(g_drv, ext_val, ext_en);
endmodule // board_pins

/* testbench/parallel_io_ports_cdfg_tb.sv */
// Purpose: Self-checking bench for the parallel port block of ports C, D, F and G.
// Assumes: Register port with one-cycle read data; pins follow their cause by one cycle.
// Notes: Expectations are recomputed here from register values written by the bench.
`timescale 1ns/1ps
module parallel_io_ports_cdfg_tb;
    import gpio_cdfg_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    reg_req_t bus_req = '0;
    op_mode_t mode = MODE_SINGLE;
    logic [7:0] rdata, c_in, d_in, g_in, db_out = 8'h00, low_addr = 8'h00, db_in;
    logic [5:0] s_in;
    logic [7:0] ext_val = 8'h00, ext_en = 8'h00, a, b, lv;
    logic [5:0] s_out = 6'h00, s_oe = 6'h00;
    logic [3:0] cs = 4'h0;
    logic db_oe = 1'b0, quad, od;
    pin_drive_t c_pins, d_pins, f_pins, g_pins;
    int miscompares = 0, compares = 0, cycles = 0;

    always #2 mclk = ~mclk;

    parallel_io_ports dut (.mclk(mclk), .rst(rst), .bus_req(bus_req), .rdata(rdata),
        .mode(mode), .port_c_pins_in(c_in), .port_c_pins(c_pins), .port_d_pins_in(d_in),
        .port_d_pins(d_pins), .port_f_pins(f_pins), .port_g_pins_in(g_in),
        .port_g_pins(g_pins), .data_bus_out(db_out), .data_bus_oe(db_oe),
        .data_bus_in(db_in), .low_address(low_addr), .serial_out(s_out), .serial_oe(s_oe),
        .serial_in(s_in), .chip_select(cs), .quad_clock_output(quad));

    board_pins board (.c_drv(c_pins), .d_drv(d_pins), .g_drv(g_pins), .ext_val(ext_val),
        .ext_en(ext_en), .c_in(c_in), .d_in(d_in), .g_in(g_in));

    // Open-drain keeps only the low-side driver, so a one in the latch releases the pin.
    function automatic logic [7:0] exp_oe(input logic [7:0] dir, data, input logic odm);
        return odm ? (dir & ~data) : dir;
    endfunction

    task automatic give_verdict();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [15:0] addr, input logic [7:0] data);
        @(posedge mclk);
        bus_req <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        bus_req <= '0;
    endtask

    // Read data stand only in the cycle after the strobe, so they are checked there.
    task automatic rd(input logic [15:0] addr, input logic [7:0] exp);
        @(posedge mclk);
        bus_req <= '{addr: addr, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        bus_req <= '0;
        #1;
        chk("rdata", rdata, exp);
    endtask

    task automatic settle();
        repeat (3) @(posedge mclk);
        #1;
    endtask

    // A hang is cut short here and counted as a mismatch.
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 6000) begin
            miscompares++;
            give_verdict();
        end
    end

    initial begin
        void'($urandom(32'hBF2EA20D));
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        #1;
        chk("c_oe", c_pins.oe, 8'h00);
        chk("d_oe", d_pins.oe, 8'h00);
        chk("g_oe", g_pins.oe, 8'h00);
        chk("f_out", f_pins.out, 8'h00);
        rd(PORT_C_DIRECTION_ADDR, 8'h00);
        rd(PORT_G_DIRECTION_ADDR, 8'h00);
        rd(16'h1010, 8'h00);
        // Random data and direction in single-chip and bootstrap, push-pull and open-drain.
        for (int i = 0; i < 8; i++) begin
            a = 8'($urandom);
            b = 8'($urandom);
            od = i[0];
            mode <= i[1] ? MODE_BOOT : MODE_SINGLE;
            ext_val <= 8'($urandom);
            ext_en <= 8'($urandom);
            wr(SYSTEM_OPTIONS_TWO_ADDR, {od, od, 1'b0, 5'($urandom)});
            rd(SYSTEM_OPTIONS_TWO_ADDR, {od, od, 6'h00});
            wr(SERIAL_PERIPH_CONTROL_ADDR, {2'b00, od, 5'h1F});
            wr(PORT_C_DATA_ADDR, b);
            wr(PORT_C_DIRECTION_ADDR, a);
            wr(PORT_D_DATA_ADDR, b);
            wr(PORT_D_DIRECTION_ADDR, a);
            wr(PORT_G_DATA_ADDR, b);
            wr(PORT_G_DIRECTION_ADDR, a);
            settle();
            lv = (ext_en & ext_val) | ~ext_en;
            chk("c_oe", c_pins.oe, exp_oe(a, b, od));
            chk("c_out", c_pins.out & c_pins.oe, (od ? 8'h00 : b) & c_pins.oe);
            chk("d_oe", d_pins.oe & 8'h3F, exp_oe(a, b, od) & 8'h3F);
            chk("d_out", d_pins.out & d_pins.oe, (od ? 8'h00 : b) & d_pins.oe);
            chk("g_oe", g_pins.oe, exp_oe(a, b, od));
            chk("g_out", g_pins.out & g_pins.oe, (od ? 8'h00 : b) & g_pins.oe);
            rd(PORT_C_DATA_ADDR, (a & b) | (~a & lv));
            rd(PORT_C_DIRECTION_ADDR, a);
            rd(PORT_G_DIRECTION_ADDR, a);
            rd(PORT_D_DATA_ADDR, ((a & b) | (~a & lv)) & 8'h3F);
        end
        // Serial units take port D pins over bit by bit.
        wr(SERIAL_PERIPH_CONTROL_ADDR, 8'h00);
        s_oe <= 6'($urandom);
        s_out <= 6'($urandom);
        cs <= 4'($urandom);
        wr(PORT_G_ALT_SELECT_ADDR, 8'hF0);
        wr(SYSTEM_OPTIONS_TWO_ADDR, 8'h00);
        settle();
        chk("d_ser_oe", d_pins.oe & 8'h3F, (a | {2'b00, s_oe}) & 8'h3F);
        chk("d_ser_out", d_pins.out & {2'b00, s_oe}, {2'b00, s_out & s_oe});
        chk("g_cs_oe", g_pins.oe & CS_ALT_MASK, CS_ALT_MASK);
        chk("g_cs_out", g_pins.out & CS_ALT_MASK, {cs, 4'h0});
        chk("s_in", {2'b00, s_in}, d_in & 8'h3F);
        // The quad clock toggles every cycle while enabled and rests low otherwise.
        wr(SYSTEM_OPTIONS_TWO_ADDR, 8'h20);
        settle();
        repeat (4) begin
            lv = {7'h00, ~quad};
            @(posedge mclk);
            #1;
            chk("quad", {7'h00, quad}, lv);
        end
        wr(SYSTEM_OPTIONS_TWO_ADDR, 8'h00);
        settle();
        chk("quad_off", {7'h00, quad}, 8'h00);
        // Expanded and test modes: bus overrides and program chip select out of reset.
        for (int k = 0; k < 2; k++) begin
            mode <= k[0] ? MODE_TEST : MODE_EXPANDED;
            db_out <= 8'($urandom);
            db_oe <= 1'b1;
            low_addr <= 8'($urandom);
            cs <= 4'($urandom);
            rst <= 1'b1;
            repeat (2) @(posedge mclk);
            rst <= 1'b0;
            settle();
            chk("g_prog_oe", g_pins.oe & 8'h80, 8'h80);
            chk("g_prog_out", g_pins.out & 8'h80, {cs[3], 7'h00});
            wr(PORT_C_DIRECTION_ADDR, 8'h0F);
            wr(SYSTEM_OPTIONS_TWO_ADDR, 8'h40);
            settle();
            chk("c_bus_oe", c_pins.oe, 8'hFF);
            chk("c_bus_out", c_pins.out, db_out);
            chk("f_addr", f_pins.out, low_addr);
            chk("db_in", db_in, db_out);
        end
        give_verdict();
    end
endmodule // parallel_io_ports_cdfg_tb

/* verilog/gpio_cdfg_pkg.sv */
// Purpose: Shared constants and types for the parallel port block of ports C, D, F and G.
// Assumes: Byte-wide register port with a 16-bit address, registers at fixed byte addresses.
// Notes: Mode encoding is Gray along single, expanded, test, bootstrap.
package gpio_cdfg_pkg;

    // Register addresses.
    localparam logic [15:0] PORT_C_DATA_ADDR = 16'h1003;
    localparam logic [15:0] PORT_F_DATA_ADDR = 16'h1005;
    localparam logic [15:0] PORT_C_DIRECTION_ADDR = 16'h1007;
    localparam logic [15:0] PORT_D_DATA_ADDR = 16'h1008;
    localparam logic [15:0] PORT_D_DIRECTION_ADDR = 16'h1009;
    localparam logic [15:0] SERIAL_PERIPH_CONTROL_ADDR = 16'h1028;
    localparam logic [15:0] SYSTEM_OPTIONS_TWO_ADDR = 16'h1038;
    localparam logic [15:0] PORT_G_DATA_ADDR = 16'h1040;
    localparam logic [15:0] PORT_G_DIRECTION_ADDR = 16'h1041;
    localparam logic [15:0] PORT_G_ALT_SELECT_ADDR = 16'h1042;

    // Field positions.
    localparam int SYSTEM_OPTIONS_TWO_PORT_G_OPEN_DRAIN_SEL_BIT = 7;
    localparam int SYSTEM_OPTIONS_TWO_PORT_C_OPEN_DRAIN_SEL_BIT = 6;
    localparam int SYSTEM_OPTIONS_TWO_QUAD_CLOCK_OUT_ENABLE_BIT = 5;
    localparam int SERIAL_PERIPH_CONTROL_PORT_D_OPEN_DRAIN_SEL_BIT = 5;
    localparam int PROG_CS_BIT = 7;

    // Masks and reset values.
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] BYTE_ONES = 8'hFF;
    localparam logic [7:0] SYSTEM_OPTIONS_TWO_IMPL_MASK = 8'hE0;
    localparam logic [7:0] SERIAL_PERIPH_CONTROL_IMPL_MASK = 8'h20;
    localparam logic [7:0] PORT_D_IMPL_MASK = 8'h3F;
    localparam logic [7:0] CS_ALT_MASK = 8'hF0;
    localparam logic [7:0] PG_ALT_RESET_EXPANDED = 8'h80;

    // Operating modes from the mode straps.
    typedef enum logic [1:0] {
        MODE_SINGLE = 2'b00,
        MODE_EXPANDED = 2'b01,
        MODE_TEST = 2'b11,
        MODE_BOOT = 2'b10
    } op_mode_t;

    // One register access from the master.
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    // Pin drive for eight pins: level and output enable.
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } pin_drive_t;

endpackage

/* verilog/parallel_io_ports.sv */
// Purpose: Parallel I/O for ports C, D, F and G with direction, open-drain and bus overrides.
// Assumes: One clock mclk at 250 MHz, synchronous active-high reset, pins sampled synchronously.
// Notes: Pin drives and read data are registered, so pins follow a register write by one cycle.
`timescale 1ns/1ps

// Notes on behaviour
// - Port C direction bit: zero input, one output; all clear on reset.
// - Port D bits 5..0 serve as plain I/O or serial unit pins in every mode.
// - During reset every port D pin is an undriven input, direction cleared.
// - Port D open-drain select removes high-side drive in every mode.
// - Port D open-drain: zero drives low, one leaves the pin floating.
// - Port G resets to inputs, except bit 7 becomes program chip select when expanded.
// - Port G bits 7..4 offer chip selects; every bit has its own direction.
// - Port G open-drain select removes high-side drive in every mode.
// - Port G open-drain: zero pulls low, one releases the pin.
// - Port G direction bit: zero input, one output; resets to zero.
// - Options-two bit 6 selects port C open-drain when set, push-pull when clear.
// - Options-two bits 4..0 are absent and read as zero.
// - Port C open-drain only acts in single-chip or bootstrap mode.
module parallel_io_ports
    import gpio_cdfg_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire reg_req_t bus_req,
    output logic [7:0] rdata,
    input wire op_mode_t mode,
    input wire logic [7:0] port_c_pins_in,
    output pin_drive_t port_c_pins,
    input wire logic [7:0] port_d_pins_in,
    output pin_drive_t port_d_pins,
    output pin_drive_t port_f_pins,
    input wire logic [7:0] port_g_pins_in,
    output pin_drive_t port_g_pins,
    input wire logic [7:0] data_bus_out,
    input wire logic data_bus_oe,
    output logic [7:0] data_bus_in,
    input wire logic [7:0] low_address,
    input wire logic [5:0] serial_out,
    input wire logic [5:0] serial_oe,
    output logic [5:0] serial_in,
    input wire logic [3:0] chip_select,
    output logic quad_clock_output
);

    // Software-visible state.
    logic [7:0] port_c_data, next_port_c_data;
    logic [7:0] port_c_direction, next_port_c_direction;
    logic [7:0] port_d_data, next_port_d_data;
    logic [7:0] port_d_direction, next_port_d_direction;
    logic [7:0] port_f_data, next_port_f_data;
    logic [7:0] port_g_data, next_port_g_data;
    logic [7:0] port_g_direction, next_port_g_direction;
    logic [7:0] port_g_alt, next_port_g_alt;
    logic [7:0] serial_periph_control, next_serial_periph_control;
    logic [7:0] system_options_two, next_system_options_two;
    logic [7:0] next_rdata;
    pin_drive_t next_port_c_pins, next_port_d_pins, next_port_f_pins, next_port_g_pins;
    logic next_quad_clock_output;
    logic expanded;
    logic port_d_open_drain_sel, port_g_open_drain_sel, port_c_open_drain_sel;
    logic quad_clock_out_enable;
    logic [7:0] port_g_value, port_c_read, port_d_read, port_g_read;

    // Drive helper: open-drain keeps the low side only, so a one floats the pin.
    function automatic pin_drive_t drive(input logic [7:0] val, input logic [7:0] en,
                                         input logic od);
        pin_drive_t d;
        d.out = od ? BYTE_ZERO : val;
        d.oe = od ? (en & ~val) : en;
        return d;
    endfunction

    // Mode decode and option bits; test mode is treated as an expanded mode.
    assign expanded = (mode == MODE_EXPANDED) || (mode == MODE_TEST);
    assign port_d_open_drain_sel = serial_periph_control[SERIAL_PERIPH_CONTROL_PORT_D_OPEN_DRAIN_SEL_BIT];
    assign port_g_open_drain_sel = system_options_two[SYSTEM_OPTIONS_TWO_PORT_G_OPEN_DRAIN_SEL_BIT];
    assign port_c_open_drain_sel = system_options_two[SYSTEM_OPTIONS_TWO_PORT_C_OPEN_DRAIN_SEL_BIT];
    assign quad_clock_out_enable = system_options_two[SYSTEM_OPTIONS_TWO_QUAD_CLOCK_OUT_ENABLE_BIT];

    // Outputs read back the latch, inputs read the pin.
    assign port_c_read = (port_c_direction & port_c_data) | (~port_c_direction & port_c_pins_in);
    assign port_d_read = ((port_d_direction & port_d_data) | (~port_d_direction & port_d_pins_in))
                         & PORT_D_IMPL_MASK;
    assign port_g_read = (port_g_direction & port_g_data) | (~port_g_direction & port_g_pins_in);

    // Port G data merged with the chip selects on bits 7..4.
    assign port_g_value = (port_g_alt & {chip_select, 4'h0}) | (~port_g_alt & port_g_data);

    // Register writes and read decode.
    always_comb begin
        next_port_c_data = port_c_data;
        next_port_c_direction = port_c_direction;
        next_port_d_data = port_d_data;
        next_port_d_direction = port_d_direction;
        next_port_f_data = port_f_data;
        next_port_g_data = port_g_data;
        next_port_g_direction = port_g_direction;
        next_port_g_alt = port_g_alt;
        next_serial_periph_control = serial_periph_control;
        next_system_options_two = system_options_two;
        next_rdata = BYTE_ZERO;
        if (bus_req.wr) begin
            case (bus_req.addr)
                PORT_C_DATA_ADDR: next_port_c_data = bus_req.wdata;
                PORT_C_DIRECTION_ADDR: next_port_c_direction = bus_req.wdata;
                PORT_D_DATA_ADDR: next_port_d_data = bus_req.wdata & PORT_D_IMPL_MASK;
                PORT_D_DIRECTION_ADDR: next_port_d_direction = bus_req.wdata & PORT_D_IMPL_MASK;
                PORT_F_DATA_ADDR: next_port_f_data = bus_req.wdata;
                PORT_G_DATA_ADDR: next_port_g_data = bus_req.wdata;
                PORT_G_DIRECTION_ADDR: next_port_g_direction = bus_req.wdata;
                PORT_G_ALT_SELECT_ADDR: next_port_g_alt = bus_req.wdata & CS_ALT_MASK;
                SERIAL_PERIPH_CONTROL_ADDR: next_serial_periph_control = bus_req.wdata & SERIAL_PERIPH_CONTROL_IMPL_MASK;
                SYSTEM_OPTIONS_TWO_ADDR: next_system_options_two = bus_req.wdata & SYSTEM_OPTIONS_TWO_IMPL_MASK;
                default: ;
            endcase
        end
        // Unmapped reads answer zero; data stands only in the cycle after the strobe.
        if (bus_req.rd) begin
            case (bus_req.addr)
                PORT_C_DATA_ADDR: next_rdata = port_c_read;
                PORT_C_DIRECTION_ADDR: next_rdata = port_c_direction;
                PORT_D_DATA_ADDR: next_rdata = port_d_read;
                PORT_D_DIRECTION_ADDR: next_rdata = port_d_direction;
                PORT_F_DATA_ADDR: next_rdata = port_f_data;
                PORT_G_DATA_ADDR: next_rdata = port_g_read;
                PORT_G_DIRECTION_ADDR: next_rdata = port_g_direction;
                PORT_G_ALT_SELECT_ADDR: next_rdata = port_g_alt;
                SERIAL_PERIPH_CONTROL_ADDR: next_rdata = serial_periph_control;
                SYSTEM_OPTIONS_TWO_ADDR: next_rdata = system_options_two & SYSTEM_OPTIONS_TWO_IMPL_MASK;
                default: next_rdata = BYTE_ZERO;
            endcase
        end
    end

    // Register the software state; port G alternate reset depends on the mode straps.
    always_ff @(posedge mclk) begin
        if (rst) begin
            port_c_data <= BYTE_ZERO;
            port_c_direction <= BYTE_ZERO;
            port_d_data <= BYTE_ZERO;
            port_d_direction <= BYTE_ZERO;
            port_f_data <= BYTE_ZERO;
            port_g_data <= BYTE_ZERO;
            port_g_direction <= BYTE_ZERO;
            port_g_alt <= expanded ? PG_ALT_RESET_EXPANDED : BYTE_ZERO;
            serial_periph_control <= BYTE_ZERO;
            system_options_two <= BYTE_ZERO;
            rdata <= BYTE_ZERO;
        end else begin
            port_c_data <= next_port_c_data;
            port_c_direction <= next_port_c_direction;
            port_d_data <= next_port_d_data;
            port_d_direction <= next_port_d_direction;
            port_f_data <= next_port_f_data;
            port_g_data <= next_port_g_data;
            port_g_direction <= next_port_g_direction;
            port_g_alt <= next_port_g_alt;
            serial_periph_control <= next_serial_periph_control;
            system_options_two <= next_system_options_two;
            rdata <= next_rdata;
        end
    end

    // Pin drive computation. Serial units take a port D pin only while they enable it,
    // so a disabled serial unit hands the pin back to the data and direction registers.
    always_comb begin
        if (expanded) begin
            next_port_c_pins = drive(data_bus_out, {8{data_bus_oe}}, 1'b0);
            next_port_f_pins = drive(low_address, BYTE_ONES, 1'b0);
        end else begin
            next_port_c_pins = drive(port_c_data, port_c_direction, port_c_open_drain_sel);
            next_port_f_pins = drive(port_f_data, BYTE_ONES, 1'b0);
        end
        next_port_d_pins = drive(((port_d_data & ~{2'b00, serial_oe}) | {2'b00, serial_oe & serial_out})
                                 & PORT_D_IMPL_MASK,
                                 (port_d_direction | {2'b00, serial_oe}) & PORT_D_IMPL_MASK,
                                 port_d_open_drain_sel);
        next_port_g_pins = drive(port_g_value, port_g_direction | port_g_alt,
                                 port_g_open_drain_sel);
        // The divider runs only while enabled, so the pin rests low when off.
        next_quad_clock_output = quad_clock_out_enable & ~quad_clock_output;
    end

    // Register pins and sampled inputs; reset leaves every pin undriven.
    always_ff @(posedge mclk) begin
        if (rst) begin
            port_c_pins <= '0;
            port_d_pins <= '0;
            port_f_pins <= '0;
            port_g_pins <= '0;
            data_bus_in <= BYTE_ZERO;
            serial_in <= 6'h00;
            quad_clock_output <= 1'b0;
        end else begin
            port_c_pins <= next_port_c_pins;
            port_d_pins <= next_port_d_pins;
            port_f_pins <= next_port_f_pins;
            port_g_pins <= next_port_g_pins;
            data_bus_in <= port_c_pins_in;
            serial_in <= port_d_pins_in[5:0];
            quad_clock_output <= next_quad_clock_output;
        end
    end

    // Checks on the registered pin behaviour.
    a_port_c_direction_reset_clear: assert property (@(posedge mclk) disable iff (rst)
        $past(rst) |-> (port_c_direction == BYTE_ZERO && port_g_direction == BYTE_ZERO))
        else $error("direction registers not cleared by reset");
    a_pd_reset_float: assert property (@(posedge mclk) disable iff (rst)
        $past(rst) |-> (port_d_pins.oe == BYTE_ZERO && port_d_direction == BYTE_ZERO))
        else $error("port D driven after reset");
    a_pd_no_high: assert property (@(posedge mclk) disable iff (rst)
        $past(port_d_open_drain_sel) |-> ((port_d_pins.oe & port_d_pins.out) == BYTE_ZERO))
        else $error("port D high side active in open-drain mode");
    a_pd_od_low: assert property (@(posedge mclk) disable iff (rst)
        (port_d_open_drain_sel && port_d_direction[0] && !port_d_data[0] && !serial_oe[0])
        |=> (port_d_pins.oe[0] && !port_d_pins.out[0]))
        else $error("port D open-drain zero not driven low");
    a_pd_serial_pin: assert property (@(posedge mclk) disable iff (rst)
        (serial_oe[1] && !port_d_open_drain_sel) |=> (port_d_pins.oe[1] && port_d_pins.out[1] == $past(serial_out[1])))
        else $error("serial output not on port D pin");
    a_pg7_prog_cs: assert property (@(posedge mclk)
        ($past(rst) && !rst && $past(expanded)) |-> port_g_alt[PROG_CS_BIT])
        else $error("program chip select not selected after expanded reset");
    a_pg_no_high: assert property (@(posedge mclk) disable iff (rst)
        $past(port_g_open_drain_sel) |-> ((port_g_pins.oe & port_g_pins.out) == BYTE_ZERO))
        else $error("port G high side active in open-drain mode");
    a_pg_od_release: assert property (@(posedge mclk) disable iff (rst)
        (port_g_open_drain_sel && port_g_data[0] && port_g_direction[0]) |=> !port_g_pins.oe[0])
        else $error("port G open-drain one still driven");
    a_pc_od_single: assert property (@(posedge mclk) disable iff (rst)
        (port_c_open_drain_sel && !expanded) |=> ((port_c_pins.oe & port_c_pins.out) == BYTE_ZERO))
        else $error("port C high side active in open-drain mode");
    a_pc_bus_lines: assert property (@(posedge mclk) disable iff (rst)
        (expanded && data_bus_oe) |=> (port_c_pins.oe == BYTE_ONES && port_c_pins.out == $past(data_bus_out)))
        else $error("port C not following data bus");
    a_pf_addr_lines: assert property (@(posedge mclk) disable iff (rst)
        expanded |=> (port_f_pins.out == $past(low_address)))
        else $error("port F not following low address");
    a_system_options_two_low_zero: assert property (@(posedge mclk) disable iff (rst)
        (bus_req.rd && bus_req.addr == SYSTEM_OPTIONS_TWO_ADDR) |=> (rdata[4:0] == 5'h00))
        else $error("options-two low bits read nonzero");
    a_pd_top_zero: assert property (@(posedge mclk) disable iff (rst)
        (bus_req.rd && bus_req.addr == PORT_D_DATA_ADDR) |=> (rdata[7:6] == 2'b00))
        else $error("port D bits 7 and 6 read nonzero");
    a_quad_clock_gate: assert property (@(posedge mclk) disable iff (rst)
        !quad_clock_out_enable |=> !quad_clock_output)
        else $error("quad clock output running while disabled");

endmodule // parallel_io_ports
